// File: core/rba_defines.svh
`ifndef RBA_DEFINES_SVH
`define RBA_DEFINES_SVH

// Register indices within the bank
`define RBA_IDX_CTRL     3'h0
`define RBA_IDX_STATUS   3'h1
`define RBA_IDX_WCMD     3'h2
`define RBA_IDX_FLAGSET  3'h3
`define RBA_IDX_FLAGCLR  3'h4
`define RBA_IDX_DBGCTRL  3'h5

// Bit masks of the implemented bits in each register
`define RBA_CTRL_MASK    8'h3f
`define RBA_STATUS_MASK  8'h1f
`define RBA_WCMD_MASK    8'h0f
`define RBA_FLAG_MASK    8'hff
`define RBA_DBG_MASK     8'h03

// Field positions
`define RBA_CTRL_MODE_LSB 4
`define RBA_CTRL_MODE_MSB 5
`define RBA_STAT_MODE_LSB 0
`define RBA_STAT_MODE_MSB 1

// Reset values
`define RBA_CTRL_RST     8'h00
`define RBA_FLAG_RST     8'h00
`define RBA_DBG_RST      8'h00
`define RBA_WCMD_RST     8'h00

// Reserved encoding of the two-bit mode field
`define RBA_MODE_RSVD    2'h3

`endif

// File: core/rba_pkg.sv
package rba_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] idx;
    logic [7:0] wdata;
  } rba_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } rba_rsp_t;

  typedef enum logic [1:0] {
    RBA_MODE_OFF  = 2'h0,
    RBA_MODE_ONE  = 2'h1,
    RBA_MODE_TWO  = 2'h2,
    RBA_MODE_RSVD = 2'h3
  } rba_mode_t;

endpackage

// File: core/rba_setclr.sv
`timescale 1ns/1ns
`include "rba_defines.svh"

module rba_setclr
  import rba_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             sw_rst,
  input  wire logic             set_we,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             clr_we,
  input  wire logic [WIDTH-1:0] clr_bits,
  input  wire logic [WIDTH-1:0] hw_set,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] stored;
  logic [WIDTH-1:0] next_stored;
  logic [WIDTH-1:0] set_m;
  logic [WIDTH-1:0] clr_m;

  always_comb
  begin
    set_m = set_we ? set_bits : '0;
    clr_m = clr_we ? clr_bits : '0;
    // Zeros in either alias leave bits alone; clear beats set
    next_stored = (stored | set_m | hw_set) & ~clr_m;
    if (sw_rst)
    begin
      next_stored = WIDTH'(`RBA_FLAG_RST);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stored <= WIDTH'(`RBA_FLAG_RST);
    end
    else
    begin
      stored <= next_stored;
    end
  end

  assign value = stored;

  setclr_clear_wins_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    (clr_we && !sw_rst) |=> ((stored & $past(clr_bits)) == '0))
    else $error("clear alias did not clear");

  setclr_set_holds_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    (set_we && !clr_we && !sw_rst)
      |=> ((stored & $past(set_bits)) == $past(set_bits)))
    else $error("set alias did not set");

  // Bits that no alias targets with a one and no event sets must not move
  setclr_keep_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    !sw_rst |=> (((stored ^ $past(stored))
                  & ~$past(set_m | clr_m | hw_set)) == '0))
    else $error("stored bits changed without write");

endmodule

// File: core/rba_rdmux.sv
`timescale 1ns/1ns
`include "rba_defines.svh"

module rba_rdmux
  import rba_pkg::*;
(
  input  wire logic [2:0] idx,
  input  wire logic [7:0] ctrl,
  input  wire logic [7:0] status,
  input  wire logic [7:0] flags,
  input  wire logic [7:0] dbg,
  output logic      [7:0] rdata
);

  always_comb
  begin
    case (idx)
      `RBA_IDX_CTRL:    rdata = ctrl & `RBA_CTRL_MASK;
      `RBA_IDX_STATUS:  rdata = status & `RBA_STATUS_MASK;
      // Write-only bits: reading yields zero, software must not rely on it
      `RBA_IDX_WCMD:    rdata = 8'h00;
      `RBA_IDX_FLAGSET: rdata = flags;
      `RBA_IDX_FLAGCLR: rdata = flags;
      `RBA_IDX_DBGCTRL: rdata = dbg & `RBA_DBG_MASK;
      default:          rdata = 8'h00;
    endcase
  end

endmodule

// File: core/rba_bank.sv
`timescale 1ns/1ns
`include "rba_defines.svh"

module rba_bank
  import rba_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sw_rst,
  input  rba_req_t        req,
  input  wire logic       set_also,
  input  wire logic [7:0] set_also_bits,
  input  wire logic [7:0] hw_events,
  input  wire logic [1:0] hw_status,
  output rba_rsp_t        rsp,
  output logic      [5:0] ctrl_out,
  output logic      [3:0] cmd_pulse,
  output logic      [7:0] flags_out,
  output logic      [1:0] dbg_out
);

  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] dbg;
  logic [7:0] next_dbg;
  logic [3:0] next_cmd;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] flags;
  logic [7:0] rdata;
  logic       set_we;
  logic       clr_we;
  rba_rsp_t   next_rsp;
  logic [7:0] also_m;

  function automatic logic hit(input rba_req_t r, input logic [2:0] i);
    hit = r.wr && (r.idx == i);
  endfunction

  // A reserved mode value is never shown in status[1:0]; it degrades to off there
  function automatic logic [1:0] safe_mode(input logic [1:0] m);
    safe_mode = (m == `RBA_MODE_RSVD) ? 2'(RBA_MODE_OFF) : m;
  endfunction

  // Implemented bits per register; everything else must read as zero
  function automatic logic [7:0] rd_mask(input logic [2:0] i);
    case (i)
      `RBA_IDX_CTRL:    rd_mask = `RBA_CTRL_MASK;
      `RBA_IDX_STATUS:  rd_mask = `RBA_STATUS_MASK;
      `RBA_IDX_FLAGSET: rd_mask = `RBA_FLAG_MASK;
      `RBA_IDX_FLAGCLR: rd_mask = `RBA_FLAG_MASK;
      `RBA_IDX_DBGCTRL: rd_mask = `RBA_DBG_MASK;
      default:          rd_mask = 8'h00;
    endcase
  endfunction

  assign set_we = hit(req, `RBA_IDX_FLAGSET) || set_also;
  // The agent's bits count only while its strobe is high, else a stale
  // value would ride along on every later software set
  assign also_m = set_also ? set_also_bits : 8'h00;
  assign clr_we = hit(req, `RBA_IDX_FLAGCLR);

  always_comb
  begin
    next_ctrl = ctrl;
    next_dbg  = dbg;
    next_cmd  = 4'h0;
    if (hit(req, `RBA_IDX_CTRL))
    begin
      // Reserved positions are dropped so they can never read back
      next_ctrl = req.wdata & `RBA_CTRL_MASK;
    end
    if (hit(req, `RBA_IDX_WCMD))
    begin
      next_cmd = req.wdata[3:0] & 4'(`RBA_WCMD_MASK);
    end
    if (hit(req, `RBA_IDX_DBGCTRL))
    begin
      next_dbg = req.wdata & `RBA_DBG_MASK;
    end
    if (sw_rst)
    begin
      next_ctrl = `RBA_CTRL_RST;
      next_cmd  = 4'(`RBA_WCMD_RST);
    end
    // Status tracks hw_status and the ctrl mode field; writes to its index are ignored
    next_status = {3'h0, ctrl[`RBA_CTRL_MODE_MSB:`RBA_CTRL_MODE_LSB] != 2'h0,
                   hw_status,
                   safe_mode(ctrl[`RBA_CTRL_MODE_MSB:`RBA_CTRL_MODE_LSB])
                   };
    next_rsp.valid = req.rd;
    next_rsp.rdata = req.rd ? rdata : 8'h00;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl      <= `RBA_CTRL_RST;
      dbg       <= `RBA_DBG_RST;
      cmd_pulse <= 4'h0;
      status    <= 8'h00;
      rsp       <= '0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      dbg       <= next_dbg;
      cmd_pulse <= next_cmd;
      status    <= next_status;
      rsp       <= next_rsp;
    end
  end

  assign ctrl_out  = ctrl[5:0];
  assign dbg_out   = dbg[1:0];
  assign flags_out = flags;

  rba_setclr #(
    .WIDTH (8)
  ) u_flags (
    .clk      (clk),
    .arst_n   (arst_n),
    .sw_rst   (sw_rst),
    .set_we   (set_we),
    .set_bits (hit(req, `RBA_IDX_FLAGSET) ? req.wdata | also_m
                                          : also_m),
    .clr_we   (clr_we),
    .clr_bits (req.wdata),
    .hw_set   (hw_events),
    .value    (flags)
  );

  rba_rdmux u_rdmux (
    .idx    (req.idx),
    .ctrl   (ctrl),
    .status (status),
    .flags  (flags),
    .dbg    (dbg),
    .rdata  (rdata)
  );

  bank_rw_store_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    (hit(req, `RBA_IDX_CTRL) && !sw_rst)
      |=> (ctrl == ($past(req.wdata) & `RBA_CTRL_MASK)))
    else $error("read-write bit did not store");

  // A write to status must not stop it from following the live inputs
  bank_ro_ignore_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    hit(req, `RBA_IDX_STATUS)
      |=> (status[7:5] == 3'h0 && status[3:2] == $past(hw_status)))
    else $error("read-only register altered");

  bank_rsvd_zero_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    rsp.valid |-> ((rsp.rdata & ~rd_mask($past(req.idx))) == 8'h00))
    else $error("reserved bits read nonzero");

  bank_mode_legal_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    status[`RBA_STAT_MODE_MSB:`RBA_STAT_MODE_LSB] != `RBA_MODE_RSVD)
    else $error("reserved mode shown");

  bank_swrst_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    sw_rst |=> (ctrl == `RBA_CTRL_RST && dbg == $past(dbg)
                && flags == `RBA_FLAG_RST))
    else $error("software reset values wrong");

  bank_alias_same_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    (req.rd && (req.idx == `RBA_IDX_FLAGSET
                || req.idx == `RBA_IDX_FLAGCLR))
      |=> (rsp.valid && rsp.rdata == $past(flags)))
    else $error("alias read mismatch");

  // A second command right behind the first replaces the pulse
  bank_wo_cmd_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    (hit(req, `RBA_IDX_WCMD) && !sw_rst)
      |=> (cmd_pulse == $past(req.wdata[3:0])) ##1
          (cmd_pulse == 4'h0
           || $past(req.wr && req.idx == `RBA_IDX_WCMD)))
    else $error("write-only command not pulsed");

  bank_clr_wins_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    (set_we && clr_we && !sw_rst)
      |=> ((flags & $past(req.wdata)) == 8'h00))
    else $error("clear did not win");

  cov_set_c:   cover property (@(posedge clk) hit(req, `RBA_IDX_FLAGSET));
  cov_clr_c:   cover property (@(posedge clk) set_we && clr_we);
  cov_swrst_c: cover property (@(posedge clk) sw_rst && dbg != 8'h00);
  cov_rsvd_c:  cover property (@(posedge clk)
    ctrl[5:4] == `RBA_MODE_RSVD);

endmodule

// File: tb/rba_bank_tb.sv
`timescale 1ns/1ns
module rba_bank_tb
  import rba_pkg::*;
  ;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sw_rst = 1'b0;
  logic        set_also = 1'b0;
  rba_req_t    req = '0;
  rba_rsp_t    rsp;
  logic [7:0]  set_also_bits = 8'h00;
  logic [7:0]  hw_events = 8'h00;
  logic [1:0]  hw_status = 2'h0;
  logic [5:0]  ctrl_out;
  logic [3:0]  cmd_pulse;
  logic [7:0]  flags_out;
  logic [1:0]  dbg_out;
  logic [7:0]  d;
  logic [7:0]  fl;
  logic [15:0] e;
  logic [31:0] seed = 32'h49d1;
  logic [15:0] q[$];
  int          bad_count = 0;
  int          checks = 0;

  always #25 clk = ~clk;

  rba_bank dut (
    .clk           (clk),
    .arst_n        (arst_n),
    .sw_rst        (sw_rst),
    .req           (req),
    .set_also      (set_also),
    .set_also_bits (set_also_bits),
    .hw_events     (hw_events),
    .hw_status     (hw_status),
    .rsp           (rsp),
    .ctrl_out      (ctrl_out),
    .cmd_pulse     (cmd_pulse),
    .flags_out     (flags_out),
    .dbg_out       (dbg_out)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Write when w is set; otherwise read, noting expected data and mask
  task automatic acc(logic w, logic [2:0] i, logic [7:0] v, logic [7:0] m);
    @(posedge clk);
    req <= '{w, !w, i, w ? v : 8'h00};
    if (!w)
      q.push_back({v, m});
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  // Read data is judged half a cycle after it lands, clear of the edge
  always @(negedge clk)
    if (rsp.valid === 1'b1)
    begin
      if (q.size() == 0)
        chk("rsp_valid", 8'h00, 8'h01);
      else
      begin
        e = q.pop_front();
        chk("rdata", e[15:8] & e[7:0], rsp.rdata & e[7:0]);
      end
    end

  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      acc(1'b0, i[2:0], 8'h00, i == 2 ? 8'h00 : 8'hff);
    repeat (6)
    begin
      // Reserved bits go out as zero
      d = rnd() & 8'h3f;
      if (d[5:4] == 2'h3)
        d[5] = 1'b0;
      @(posedge clk);
      hw_status <= d[1:0];
      acc(1'b1, 3'h0, d, 8'h00);
      chk("ctrl_out", d & 8'h3f, {2'b00, ctrl_out});
      acc(1'b0, 3'h0, d, 8'hff);
      acc(1'b1, 3'h1, 8'h0c, 8'h00);
      acc(1'b0, 3'h1, {3'h0, d[5:4] != 2'h0, d[1:0], d[5:4]}, 8'hff);
      acc(1'b0, 3'h7, 8'h00, 8'hff);
    end
    acc(1'b1, 3'h2, 8'h0a, 8'h00);
    chk("cmd_pulse", 8'h0a, {4'h0, cmd_pulse});
    @(posedge clk);
    #1;
    chk("cmd_pulse", 8'h00, {4'h0, cmd_pulse});
    fl = 8'h00;
    repeat (6)
    begin
      d = rnd();
      acc(1'b1, 3'h3, d, 8'h00);
      fl |= d;
      acc(1'b0, 3'h4, fl, 8'hff);
      d = rnd();
      acc(1'b1, 3'h4, d, 8'h00);
      fl &= ~d;
      acc(1'b0, 3'h3, fl, 8'hff);
      chk("flags_out", fl, flags_out);
    end
    @(posedge clk);
    set_also <= 1'b1;
    set_also_bits <= 8'hf0;
    req <= '{1'b1, 1'b0, 3'h4, 8'h3c};
    @(posedge clk);
    set_also <= 1'b0;
    req <= '0;
    #1;
    fl = (fl | 8'hf0) & 8'hc3;
    chk("flags_out", fl, flags_out);
    @(posedge clk);
    hw_events <= 8'h81;
    @(posedge clk);
    hw_events <= 8'h00;
    #1;
    fl |= 8'h81;
    acc(1'b1, 3'h3, 8'h00, 8'h00);
    acc(1'b1, 3'h4, 8'h00, 8'h00);
    chk("flags_out", fl, flags_out);
    acc(1'b1, 3'h5, 8'h02, 8'h00);
    acc(1'b1, 3'h0, 8'h15, 8'h00);
    @(posedge clk);
    sw_rst <= 1'b1;
    @(posedge clk);
    sw_rst <= 1'b0;
    #1;
    chk("ctrl_out", 8'h00, {2'b00, ctrl_out});
    chk("flags_out", 8'h00, flags_out);
    chk("dbg_out", 8'h02, {6'h00, dbg_out});
    acc(1'b0, 3'h5, 8'h02, 8'hff);
    acc(1'b1, 3'h3, 8'hff, 8'h00);
    #10;
    arst_n = 1'b0;
    #5;
    chk("flags_out", 8'h00, flags_out);
    chk("dbg_out", 8'h00, {6'h00, dbg_out});
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("pending", 8'h00, 8'(q.size()));
    end_sim();
  end

  initial
  begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule
